// >>> fsd_map.vh
// constants for the feature settings decoder: offsets, fields, reset values
`ifndef FSD_MAP_VH
`define FSD_MAP_VH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define FSD_OFF_CMD        12'h000
`define FSD_OFF_PARAM      12'h004
`define FSD_OFF_RESULT     12'h008
`define FSD_OFF_STATUS     12'h00c
`define FSD_OFF_CFG        12'h010
`define FSD_OFF_RECOVERY   12'h014
// ----------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------
`define FSD_CMD_GO_BIT     31
`define FSD_CMD_GET_BIT    30
`define FSD_CMD_FID_LSB    16
`define FSD_CMD_NAMESPACE_IDENTIFIER_LSB   0
`define FSD_FID_TEMP       8'h04
`define FSD_FID_ERR        8'h05
`define FSD_FID_WCACHE     8'h06
// ----------------------------------------------------------------
// parameter dword fields
// ----------------------------------------------------------------
`define FSD_KIND_LSB       20
`define FSD_SEL_LSB        16
`define FSD_UBE_BIT        16
`define FSD_WCE_BIT        0
`define FSD_SEL_ALL        4'hf
`define FSD_SEL_MAX        4'h8
`define FSD_KIND_OVER      2'h0
`define FSD_KIND_UNDER     2'h1
// ----------------------------------------------------------------
// reset values, sizes and timing
// ----------------------------------------------------------------
`define FSD_OVER_RST       16'hffff
`define FSD_UNDER_RST      16'h0000
`define FSD_NS_COUNT       16
`define FSD_NS_W           4
`define FSD_SENSORS        9
`define FSD_STEP_MS        100
`define FSD_CLK_KHZ        50000
`endif

// >>> fsd_thresh_bank.v
// temperature threshold store, one over and one under value per sensor
`default_nettype none
module fsd_thresh_bank (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // write side
   input  wire        wr_en,
   input  wire        wr_all,
   input  wire [3:0]  wr_sel,
   input  wire        wr_under,
   input  wire [15:0] wr_value,
   // read side
   input  wire [3:0]  rd_sel,
   input  wire        rd_under,
   output wire [15:0] rd_value
);
`include "fsd_map.vh"
   reg [15:0] over_ff  [0:8];
   reg [15:0] under_ff [0:8];
   integer    i;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < `FSD_SENSORS; i = i + 1) begin
            over_ff[i]  <= `FSD_OVER_RST;
            under_ff[i] <= `FSD_UNDER_RST;
         end
      end else if (wr_en) begin
         for (i = 0; i < `FSD_SENSORS; i = i + 1) begin
            // all-sensors selector writes every implemented sensor
            if (wr_all || (wr_sel == i[3:0])) begin
               if (wr_under)
                  under_ff[i] <= wr_value;
               else
                  over_ff[i]  <= wr_value;
            end
         end
      end
   end

   assign rd_value = rd_under ? under_ff[rd_sel] : over_ff[rd_sel];
endmodule
`default_nettype wire

// >>> fsd_retry_timer.v
// retry time limit counter for error recovery of limited-retry commands
`include "fsd_map.vh"
`default_nettype none
module fsd_retry_timer #(
   parameter STEP_CYCLES = `FSD_STEP_MS * `FSD_CLK_KHZ
) (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // control
   input  wire [15:0] limit,
   input  wire        limited_cmd,
   input  wire        recovery_active,
   // status
   output reg         expired_ff
);
   reg [22:0] step_cnt_ff;
   reg [15:0] unit_cnt_ff;
   wire       armed;

   // only limited-retry commands with a non-zero limit are timed
   assign armed = limited_cmd && (limit != 16'h0000);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_cnt_ff <= 23'h000000;
         unit_cnt_ff <= 16'h0000;
         expired_ff  <= 1'b0;
      end else if (!recovery_active || !armed) begin
         // count starts only once recovery actions begin
         step_cnt_ff <= 23'h000000;
         unit_cnt_ff <= 16'h0000;
         expired_ff  <= 1'b0;
      end else if (!expired_ff) begin
         if (step_cnt_ff == STEP_CYCLES[22:0] - 23'h000001) begin
            step_cnt_ff <= 23'h000000;
            unit_cnt_ff <= unit_cnt_ff + 16'h0001;
            if (unit_cnt_ff + 16'h0001 == limit)
               expired_ff <= 1'b1;
         end else begin
            step_cnt_ff <= step_cnt_ff + 23'h000001;
         end
      end
   end
endmodule
`default_nettype wire

// >>> fsd_feature_decoder.v
// feature settings decoder: set/get of thresholds, error recovery, write cache
//
// Contract
// - selector 0 composite, 1-8 sensors, 9-14 reserved, 15 means all on set.
// - all-sensors selector is reserved in a get command.
// - store bits 15:0 for selected sensor and kind on set.
// - get of recovery or cache returns fields in set layout.
// - bit 16 enables unwritten block error for the named namespace only.
// - unwritten block error enable resets to zero for all namespaces.
// - bits 15:0 are retry time limit in 100 ms steps.
// - limit applies only to limited-retry I/O commands.
// - timer starts when error recovery begins, not at receipt.
// - limit of zero means no time limit.
// - write cache setting exists when a volatile cache is present.
// - bit 0 turns volatile cache on or off; bits 31:1 reserved.
// - cache enable is ignored when cache is power-loss safe.
// - recovery bits 31:17 reserved and read as zero.
// - bits 21:20 kind: 0 over, 1 under, 2-3 reserved.
// - over thresholds reset to all ones, under thresholds to zero.
// - get of thresholds returns the value picked by selector and kind.
`include "fsd_map.vh"
`default_nettype none
module fsd_feature_decoder #(
   parameter STEP_CYCLES = `FSD_STEP_MS * `FSD_CLK_KHZ,
   parameter SENSOR_MASK = 9'h1ff
) (
   // apb clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // controller options
   input  wire        cache_present,
   input  wire        cache_nonvolatile,
   // retry timing and active namespace from the command engine
   input  wire        limited_cmd,
   input  wire        recovery_active,
   input  wire [3:0]  active_ns,
   // setting outputs
   output wire        cache_on,
   output wire        unwritten_error_on,
   output wire        retry_expired
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   localparam ST_IDLE = 2'b01;
   localparam ST_EXEC = 2'b10;

   reg  [1:0]  state_ff;
   reg  [1:0]  nxt_state;
   reg  [31:0] cmd_ff;
   reg  [31:0] param_ff;
   reg  [31:0] result_ff;
   reg  [31:0] nxt_result;
   reg         done_ff;
   reg         err_ff;
   reg         nxt_err;
   reg         write_cache_enable_ff;
   reg  [15:0] retry_time_limit_ff;
   reg  [`FSD_NS_COUNT-1:0] unwritten_block_error_enable_ff;
   reg         apply;

   wire        acc;
   wire        wr;
   wire        rd;
   wire        is_get;
   wire [7:0]  fid;
   wire [3:0]  namespace_identifier;
   wire [3:0]  sensor_selector;
   wire [1:0]  threshold_kind;
   wire [15:0] threshold_value;
   wire [15:0] th_rd;
   wire        map_hit;

   assign acc = psel && penable;
   assign wr  = acc && pwrite;
   assign rd  = acc && !pwrite;
   assign pready = 1'b1;

   assign is_get               = cmd_ff[`FSD_CMD_GET_BIT];
   assign fid                  = cmd_ff[`FSD_CMD_FID_LSB +: 8];
   assign namespace_identifier = cmd_ff[`FSD_CMD_NAMESPACE_IDENTIFIER_LSB +: `FSD_NS_W];
   assign sensor_selector      = param_ff[`FSD_SEL_LSB +: 4];
   assign threshold_kind       = param_ff[`FSD_KIND_LSB +: 2];
   assign threshold_value      = param_ff[15:0];

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function sensor_ok;
      input [3:0] sel;
      input       get;
      input [8:0] mask;
      begin
         if (sel == `FSD_SEL_ALL)
            sensor_ok = !get;
         else if (sel > `FSD_SEL_MAX)
            sensor_ok = 1'b0;
         else
            sensor_ok = mask[sel];
      end
   endfunction

   function addr_is;
      input [11:0] a;
      input [11:0] off;
      begin
         addr_is = (a == off);
      end
   endfunction

   assign map_hit = addr_is(paddr, `FSD_OFF_CMD)    || addr_is(paddr, `FSD_OFF_PARAM)  ||
                    addr_is(paddr, `FSD_OFF_RESULT) || addr_is(paddr, `FSD_OFF_STATUS) ||
                    addr_is(paddr, `FSD_OFF_CFG)    || addr_is(paddr, `FSD_OFF_RECOVERY);
   assign pslverr = acc && !map_hit;

   // ----------------------------------------------------------------
   // command execution
   // ----------------------------------------------------------------
   always @* begin
      nxt_state  = state_ff;
      nxt_result = result_ff;
      nxt_err    = err_ff;
      apply      = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (wr && addr_is(paddr, `FSD_OFF_CMD) && pwdata[`FSD_CMD_GO_BIT])
               nxt_state = ST_EXEC;
         end
         ST_EXEC: begin
            nxt_state  = ST_IDLE;
            nxt_err    = 1'b0;
            nxt_result = 32'h00000000;
            case (fid)
               `FSD_FID_TEMP: begin
                  if (threshold_kind > `FSD_KIND_UNDER ||
                      !sensor_ok(sensor_selector, is_get, SENSOR_MASK))
                     nxt_err = 1'b1;
                  else if (is_get)
                     nxt_result = {16'h0000, th_rd};
                  else
                     apply = 1'b1;
               end
               `FSD_FID_ERR: begin
                  if (is_get)
                     nxt_result = {15'h0000,
                                   unwritten_block_error_enable_ff[namespace_identifier],
                                   retry_time_limit_ff};
                  else
                     apply = 1'b1;
               end
               `FSD_FID_WCACHE: begin
                  if (!cache_present)
                     nxt_err = 1'b1;
                  else if (is_get)
                     nxt_result = {31'h00000000, write_cache_enable_ff};
                  else
                     apply = 1'b1;
               end
               default: nxt_err = 1'b1;
            endcase
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   fsd_thresh_bank u_bank (
      .pclk     (pclk),
      .presetn  (presetn),
      .wr_en    (apply && (fid == `FSD_FID_TEMP)),
      .wr_all   (sensor_selector == `FSD_SEL_ALL),
      .wr_sel   (sensor_selector),
      .wr_under (threshold_kind == `FSD_KIND_UNDER),
      .wr_value (threshold_value),
      .rd_sel   (sensor_selector),
      .rd_under (threshold_kind == `FSD_KIND_UNDER),
      .rd_value (th_rd)
   );

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff   <= ST_IDLE;
         cmd_ff     <= 32'h00000000;
         param_ff   <= 32'h00000000;
         result_ff  <= 32'h00000000;
         done_ff    <= 1'b0;
         err_ff     <= 1'b0;
         write_cache_enable_ff           <= 1'b0;
         retry_time_limit_ff             <= 16'h0000;
         unwritten_block_error_enable_ff <= {`FSD_NS_COUNT{1'b0}};
      end else begin
         state_ff  <= nxt_state;
         result_ff <= nxt_result;
         err_ff    <= nxt_err;
         // completion wins over a clear of the done flag
         if (state_ff == ST_EXEC)
            done_ff <= 1'b1;
         else if (wr && addr_is(paddr, `FSD_OFF_STATUS) && pwdata[0])
            done_ff <= 1'b0;
         if (state_ff == ST_IDLE) begin
            if (wr && addr_is(paddr, `FSD_OFF_CMD))
               cmd_ff <= pwdata;
            if (wr && addr_is(paddr, `FSD_OFF_PARAM))
               param_ff <= pwdata;
         end
         if (apply && fid == `FSD_FID_ERR) begin
            retry_time_limit_ff <= threshold_value;
            unwritten_block_error_enable_ff[namespace_identifier] <=
               param_ff[`FSD_UBE_BIT];
         end
         if (apply && fid == `FSD_FID_WCACHE)
            write_cache_enable_ff <= param_ff[`FSD_WCE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always @* begin
      prdata = 32'h00000000;
      if (rd) begin
         if (addr_is(paddr, `FSD_OFF_CMD))
            prdata = cmd_ff;
         else if (addr_is(paddr, `FSD_OFF_PARAM))
            prdata = param_ff;
         else if (addr_is(paddr, `FSD_OFF_RESULT))
            prdata = result_ff;
         else if (addr_is(paddr, `FSD_OFF_STATUS))
            prdata = {29'h00000000, (state_ff == ST_EXEC), err_ff, done_ff};
         else if (addr_is(paddr, `FSD_OFF_CFG))
            prdata = {31'h00000000, write_cache_enable_ff};
         else if (addr_is(paddr, `FSD_OFF_RECOVERY))
            prdata = {16'h0000, retry_time_limit_ff};
      end
   end

   // ----------------------------------------------------------------
   // setting outputs
   // ----------------------------------------------------------------
   // a power-loss safe cache stays on whatever the enable says
   assign cache_on = cache_present &&
                     (cache_nonvolatile || write_cache_enable_ff);
   assign unwritten_error_on = unwritten_block_error_enable_ff[active_ns];

   fsd_retry_timer #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_timer (
      .pclk            (pclk),
      .presetn         (presetn),
      .limit           (retry_time_limit_ff),
      .limited_cmd     (limited_cmd),
      .recovery_active (recovery_active),
      .expired_ff      (retry_expired)
   );
endmodule
`default_nettype wire

// >>> fsd_checker_sva.sv
// port assertions for the feature settings decoder
`default_nettype none
module fsd_checker (
   // apb side
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // settings side
   input wire logic        cache_present,
   input wire logic        cache_nonvolatile,
   input wire logic        limited_cmd,
   input wire logic        recovery_active,
   input wire logic        cache_on,
   input wire logic        unwritten_error_on,
   input wire logic        retry_expired
);
   timeunit 1ns;
   timeprecision 1ns;
   logic cmd_seen_ff;
   // ----------------------------------------------------------------
   // helper and sequences
   // ----------------------------------------------------------------
   // marks that a command write has reached the block since reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_seen_ff <= 1'b0;
      end else if (psel && penable && pwrite && paddr == 12'h000) begin
         cmd_seen_ff <= 1'b1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc;
      psel && penable;
   endsequence
   sequence s_rd;
      s_acc ##0 !pwrite;
   endsequence
   sequence s_run_start;
      $rose(recovery_active) && limited_cmd;
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   chk_zero_wait: assert property (s_acc |-> pready)
      else $error("pready low in access phase");
   chk_unmapped_err: assert property (s_acc ##0 (paddr > 12'h014 || paddr[1:0] != 2'h0)
                                      |-> pslverr)
      else $error("no slave error on unmapped address");
   chk_mapped_ok: assert property (s_acc ##0 (paddr <= 12'h014 && paddr[1:0] == 2'h0)
                                   |-> !pslverr)
      else $error("slave error on mapped address");
   chk_idle_rdata: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read access");
   chk_recov_reserved: assert property (s_rd ##0 paddr == 12'h014 |-> prdata[31:16] == 16'h0)
      else $error("reserved recovery bits not zero");
   chk_cfg_reserved: assert property (s_rd ##0 paddr == 12'h010 |-> prdata[31:1] == 31'h0)
      else $error("reserved cache bits not zero");
   chk_no_cache: assert property (!cache_present |-> !cache_on)
      else $error("cache on without cache");
   chk_cache_safe: assert property (cache_present && cache_nonvolatile |-> cache_on)
      else $error("safe cache turned off");
   chk_ube_reset: assert property (!cmd_seen_ff |-> !unwritten_error_on)
      else $error("block error enabled before any command");
   chk_retry_start: assert property (s_run_start |=> !retry_expired [*8])
      else $error("retry expired too soon after recovery start");
   chk_retry_scope: assert property (retry_expired |-> $past(limited_cmd) && $past(recovery_active))
      else $error("retry expired outside limited recovery");
endmodule
`default_nettype wire

// >>> fsd_host_model.sv
// host model: apb master issuing set and get feature commands
`include "fsd_map.vh"
`default_nettype none
module fsd_host_model (
   // apb clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb master
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [11:0] paddr,
   output var  logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   int to_cnt;
   initial begin
      to_cnt = 0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // ----------------------------------------------------------------
   // bus and command tasks
   // ----------------------------------------------------------------
   task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                           output logic [31:0] q, output logic err);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) to_cnt++;
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // parameter dword first, then the command, then poll done and fetch result
   task automatic run_cmd(input logic get, input logic [7:0] fid, input logic [3:0] ns,
                          input logic [31:0] prm, output logic [31:0] res, output logic bad);
      logic [31:0] q;
      logic        e;
      int          i;
      apb_xfer(1'b1, `FSD_OFF_PARAM, prm, q, e);
      apb_xfer(1'b1, `FSD_OFF_CMD, {1'b1, get, 6'h0, fid, 12'h0, ns}, q, e);
      i = 0;
      q = 32'h0;
      while (q[0] !== 1'b1 && i < 8) begin
         apb_xfer(1'b0, `FSD_OFF_STATUS, 32'h0, q, e);
         i++;
      end
      if (q[0] !== 1'b1) to_cnt++;
      bad = q[1];
      apb_xfer(1'b0, `FSD_OFF_RESULT, 32'h0, res, e);
      apb_xfer(1'b1, `FSD_OFF_STATUS, 32'h1, q, e);
   endtask
endmodule
`default_nettype wire

// >>> fsd_tb.sv
// self-checking testbench for the feature settings decoder
`include "fsd_map.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, cache_present, cache_nonvolatile, limited_cmd, recovery_active;
   logic [3:0]  active_ns;
   wire  logic  psel, penable, pwrite, pready, pslverr, cache_on, unwritten_error_on;
   wire  logic  retry_expired;
   wire  logic [11:0] paddr;
   wire  logic [31:0] pwdata, prdata;
   int          error_cnt, cmp_count, n;
   logic [31:0] r;
   logic        b;
   logic [31:0] bad_prm [4] = '{32'h000f_0000, 32'h0009_0000, 32'h000e_0000, 32'h0023_0000};
   fsd_feature_decoder #(.STEP_CYCLES(10), .SENSOR_MASK(9'h1ff)) fsd_feature_decoder_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cache_present(cache_present), .cache_nonvolatile(cache_nonvolatile),
      .limited_cmd(limited_cmd), .recovery_active(recovery_active), .active_ns(active_ns),
      .cache_on(cache_on), .unwritten_error_on(unwritten_error_on),
      .retry_expired(retry_expired));
   fsd_host_model host_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // ----------------------------------------------------------------
   // compare, command, recovery and closing tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cmd(input logic get, input logic [7:0] fid, input logic [3:0] ns,
                      input logic [31:0] prm, input logic [31:0] er, input logic eb);
      host_inst.run_cmd(get, fid, ns, prm, r, b);
      chk({31'h0, b}, {31'h0, eb}, "error flag");
      if (get) chk(r, er, "result");
   endtask
   // recovery run; n is edges until expiry, 60 when it never expires
   task automatic recover(input logic lc);
      @(posedge pclk);
      limited_cmd <= lc;
      recovery_active <= 1'b1;
      n = 0;
      while (retry_expired !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      recovery_active <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({31'h0, retry_expired}, 32'h0, "expiry cleared");
   endtask
   task automatic end_of_test;
      chk(host_inst.to_cnt, 32'h0, "bus timeouts");
      $display("counts: errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      cache_present = 1'b1;
      cache_nonvolatile = 1'b0;
      limited_cmd = 1'b0;
      recovery_active = 1'b0;
      active_ns = 4'h5;
      error_cnt = 0;
      cmp_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      cmd(1'b1, `FSD_FID_TEMP, 4'h0, 32'h0000_0000, 32'h0000_ffff, 1'b0);
      cmd(1'b1, `FSD_FID_TEMP, 4'h0, 32'h0018_0000, 32'h0000_0000, 1'b0);
      cmd(1'b0, `FSD_FID_TEMP, 4'h0, 32'h0003_1234, 32'h0, 1'b0);
      cmd(1'b1, `FSD_FID_TEMP, 4'h0, 32'h0003_0000, 32'h0000_1234, 1'b0);
      cmd(1'b0, `FSD_FID_TEMP, 4'h0, 32'h001f_0055, 32'h0, 1'b0);
      cmd(1'b1, `FSD_FID_TEMP, 4'h0, 32'h0010_0000, 32'h0000_0055, 1'b0);
      cmd(1'b1, `FSD_FID_TEMP, 4'h0, 32'h0018_0000, 32'h0000_0055, 1'b0);
      for (int i = 0; i < 4; i++) begin
         cmd(1'b1, `FSD_FID_TEMP, 4'h0, bad_prm[i], 32'h0, 1'b1);
      end
      for (int i = 1; i < 4; i++) begin
         cmd(1'b0, `FSD_FID_TEMP, 4'h0, bad_prm[i] | 32'h7777, 32'h0, 1'b1);
      end
      cmd(1'b1, `FSD_FID_TEMP, 4'h0, 32'h0003_0000, 32'h0000_1234, 1'b0);
      cmd(1'b1, `FSD_FID_ERR, 4'h5, 32'h0, 32'h0, 1'b0);
      // namespace 5 is taken as one that supports the block error
      cmd(1'b0, `FSD_FID_ERR, 4'h5, 32'hffff_0003, 32'h0, 1'b0);
      host_inst.apb_xfer(1'b0, `FSD_OFF_RECOVERY, 32'h0, r, b);
      chk(r, 32'h0000_0003, "recovery read");
      cmd(1'b1, `FSD_FID_ERR, 4'h5, 32'h0, 32'h0001_0003, 1'b0);
      cmd(1'b1, `FSD_FID_ERR, 4'h4, 32'h0, 32'h0000_0003, 1'b0);
      chk({31'h0, unwritten_error_on}, 32'h1, "block error ns5");
      active_ns <= 4'h4;
      @(posedge pclk);
      chk({31'h0, unwritten_error_on}, 32'h0, "block error ns4");
      recover(1'b1);
      chk({31'h0, n >= 29 && n <= 32}, 32'h1, "retry limit time");
      recover(1'b0);
      chk(n, 32'd60, "unlimited command");
      cmd(1'b0, `FSD_FID_ERR, 4'h5, 32'h0, 32'h0, 1'b0);
      recover(1'b1);
      chk(n, 32'd60, "zero limit");
      cmd(1'b0, `FSD_FID_WCACHE, 4'h0, 32'hffff_ffff, 32'h0, 1'b0);
      cmd(1'b1, `FSD_FID_WCACHE, 4'h0, 32'h0, 32'h0000_0001, 1'b0);
      chk({31'h0, cache_on}, 32'h1, "cache on");
      host_inst.apb_xfer(1'b0, `FSD_OFF_CFG, 32'h0, r, b);
      chk(r, 32'h1, "cfg read");
      cmd(1'b0, `FSD_FID_WCACHE, 4'h0, 32'h0, 32'h0, 1'b0);
      chk({31'h0, cache_on}, 32'h0, "cache off");
      cache_nonvolatile <= 1'b1;
      @(posedge pclk);
      chk({31'h0, cache_on}, 32'h1, "safe cache");
      cache_present <= 1'b0;
      cmd(1'b1, `FSD_FID_WCACHE, 4'h0, 32'h0, 32'h0, 1'b1);
      host_inst.apb_xfer(1'b0, 12'h020, 32'h0, r, b);
      chk({r[30:0], b}, 32'h1, "unmapped read");
      cmd(1'b1, 8'h07, 4'h0, 32'h0, 32'h0, 1'b1);
      // reset in mid-run brings thresholds back to their reset values
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cmd(1'b1, `FSD_FID_TEMP, 4'h0, 32'h0003_0000, 32'h0000_ffff, 1'b0);
      cmd(1'b1, `FSD_FID_TEMP, 4'h0, 32'h0013_0000, 32'h0000_0000, 1'b0);
      end_of_test();
   end
endmodule
bind fsd_feature_decoder fsd_checker fsd_checker_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cache_present(cache_present), .cache_nonvolatile(cache_nonvolatile),
   .limited_cmd(limited_cmd), .recovery_active(recovery_active), .cache_on(cache_on),
   .unwritten_error_on(unwritten_error_on), .retry_expired(retry_expired));
`default_nettype wire
